// ==== shared/tplc_pkg.sv ====
// Shared constants, modes and carriers for the tape line coder
package tplc_pkg;

	// Clock and bit timing
	localparam int unsigned TPLC_CLK_HZ       = 25_000_000;   // Core clock rate
	localparam int unsigned TPLC_BIT_RATE_BPS = 3_125_000;    // Coded line bit rate
	localparam int unsigned TPLC_HALF_BIT_CYC = TPLC_CLK_HZ / (2 * TPLC_BIT_RATE_BPS);
	localparam int unsigned TPLC_BIT_CYC      = 2 * TPLC_HALF_BIT_CYC;
	localparam logic [3:0]  TPLC_HALF_LAST    = 4'(TPLC_HALF_BIT_CYC - 1);

	// Scrambler register and its feedback taps
	localparam int unsigned TPLC_LFSR_STAGES = 15;            // Stage count
	localparam int unsigned TPLC_TAP_14      = 13;            // Index of fourteenth stage
	localparam int unsigned TPLC_TAP_15      = 14;            // Index of fifteenth stage
	localparam logic [14:0] TPLC_LFSR_RESET  = 15'h0000;      // Value after reset

	// Serializer
	localparam int unsigned TPLC_WORD_W    = 8;               // Bits per source word
	localparam int unsigned TPLC_FIFO_DEPTH = 4;              // Words buffered
	localparam logic [2:0]  TPLC_WORD_LAST = 3'h7;            // Bits left after load

	// Playback bit synchronizer
	localparam int unsigned TPLC_PHASE_W   = 16;              // Phase accumulator width
	localparam logic [15:0] TPLC_NCO_STEP  = 16'(65536 / TPLC_BIT_CYC);
	localparam logic [15:0] TPLC_PHASE_MID = 16'h8000;        // Mid-bit phase
	localparam int unsigned TPLC_LOOP_SHIFT = 5;              // Loop gain, about 3 percent
	localparam int unsigned TPLC_DC_SHIFT   = 6;              // Baseline filter constant
	localparam logic [15:0] TPLC_PHASE_RESET = 16'h0000;
	localparam logic [15:0] TPLC_BASE_RESET  = 16'h0000;

	// Exactly two recording codes
	typedef enum logic {
		TPLC_SPLIT_PHASE_LEVEL_CODE,
		TPLC_SCRAMBLED_LEVEL_CODE
	} tplc_mode_t;

	// Encoder source selection
	typedef enum logic [1:0] {
		TPLC_TX_IDLE,
		TPLC_TX_SIG,
		TPLC_TX_DATA
	} tplc_tx_state_t;

	// Static configuration carried as one group
	typedef struct packed {
		tplc_mode_t mode;           // Selected recording code
		logic       low_rate;       // Playback runs below 1 Mb/s
		logic       signature_en;   // Send alignment signature
	} tplc_cfg_t;

	// Recovered bit with its strobe
	typedef struct packed {
		logic data;
		logic valid;
	} tplc_rx_bit_t;

endpackage

// ==== hw/tplc_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none

// Small word FIFO with valid and ready on both sides
module tplc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	// Clock, reset and enable
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic             ce_in,
	// Fill side
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	// Drain side
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic [WIDTH-1:0]      rd_data_out
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];     // Storage words
	logic [AW-1:0]    wr_ptr_q, wr_ptr_d; // Write index
	logic [AW-1:0]    rd_ptr_q, rd_ptr_d; // Read index
	logic [AW:0]      cnt_q, cnt_d;       // Words held
	logic             push;
	logic             pop;

	// Honest full and empty from the word count
	assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
	assign rd_valid_out = (cnt_q != '0);
	assign rd_data_out  = mem_q[rd_ptr_q];
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_valid_out && rd_ready_in;

	// Pointer and count update
	always_comb begin
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		cnt_d    = cnt_q;
		if (push) begin
			wr_ptr_d = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
		end
		if (pop) begin
			rd_ptr_d = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// Registers, frozen while the enable is low
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else if (ce_in) begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			cnt_q    <= cnt_d;
		end
	end

	// Storage words, one per entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_word
		always_ff @(posedge clk_in) begin
			if (ce_in && push && (wr_ptr_q == AW'(i))) begin
				mem_q[i] <= wr_data_in;
			end
		end
	end

endmodule

`default_nettype wire

// ==== hw/tplc_line_coder.sv ====
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RULE1 - Scrambler uses fifteen-stage register, xor adders
// RULE2 - Coded bit is data xor taps 14, 15
// RULE3 - Descrambler shifts in the received coded stream
// RULE4 - Encoder feeds back output; decoder xors taps
// RULE5 - Only split-phase or scrambled level code
// RULE6 - Split-phase: one high-low, zero low-high
// RULE7 - Operator picks split-phase within its rate limit
// RULE8 - Operator picks scrambled for high rate, time
// RULE9 - Scrambled code unsuited below 200 kb/s
// RULE10 - Split-phase playback not below 5 kb/s
// RULE11 - Density limits 590 and 980 b/mm
// RULE12 - Rate limits 3600/6000 kb/s, halve per speed
// RULE13 - Track signal strictly two-level, input regenerated
// RULE14 - Whole coded stream on one track
// RULE15 - Baseline restoration for slow scrambled playback
// RULE16 - Tracking loop bandwidth 0.1 to 3 percent
// RULE17 - Predetection rate limits versus carrier frequency
// RULE18 - Post-detection playback lower rate limits
// RULE19 - Signature sent at the payload bit rate
// RULE20 - Copies are regenerated before recording
module tplc_line_coder
	import tplc_pkg::*;
(
	// Clock, reset and enable
	input  wire logic                   clk_in,
	input  wire logic                   reset_in,
	input  wire logic                   ce_in,
	// Configuration
	input  wire tplc_cfg_t              cfg_in,
	// Source words to record
	input  wire logic                   src_valid_in,
	output logic                        src_ready_out,
	input  wire logic [TPLC_WORD_W-1:0] src_data_in,
	// Record track
	output logic                        track_out,
	// Playback track samples, signed amplitude
	input  wire logic [7:0]             play_sample_in,
	// Playback results
	output logic                        play_level_out,
	output tplc_rx_bit_t                play_bit_out
);

	// Word buffer between the source and the serializer
	logic                   buf_valid;    // A word is waiting
	logic                   buf_pop;      // Serializer takes the word
	logic [TPLC_WORD_W-1:0] buf_data;     // Waiting word

	tplc_fifo #(
		.WIDTH (TPLC_WORD_W),
		.DEPTH (TPLC_FIFO_DEPTH)
	) u_fifo (
		.clk_in       (clk_in),
		.reset_in     (reset_in),
		.ce_in        (ce_in),
		.wr_valid_in  (src_valid_in),
		.wr_ready_out (src_ready_out),
		.wr_data_in   (src_data_in),
		.rd_valid_out (buf_valid),
		.rd_ready_in  (buf_pop),
		.rd_data_out  (buf_data)
	);

	// Record side
	// A new bit is chosen every two half cells, word bits first
	// The scrambler register advances once per bit in both codes
	tplc_tx_state_t         tx_state_q, tx_state_d;   // Source of the current bit
	logic [3:0]             half_cnt_q, half_cnt_d;   // Cycles within a half cell
	logic                   cell_q, cell_d;           // Zero first half, one second
	logic [TPLC_WORD_W-1:0] shift_q, shift_d;         // Remaining word bits
	logic [2:0]             left_q, left_d;           // Bits left in the word
	logic [1:0]             sig_cnt_q, sig_cnt_d;     // Signature pattern phase
	logic [14:0]            enc_lfsr_q, enc_lfsr_d;   // Encoder scrambler stages
	logic                   coded_q, coded_d;         // Coded value of this bit
	logic                   track_q, track_d;         // Level on the track
	logic                   half_tick;                // Last cycle of a half cell
	logic                   raw_bit;                  // Bit chosen for the next cell
	logic                   scr_bit;                  // Scrambled form of that bit

	assign half_tick = (half_cnt_q == TPLC_HALF_LAST);
	// Data xor the fourteenth and fifteenth stages
	assign scr_bit   = raw_bit ^ enc_lfsr_q[TPLC_TAP_14] ^ enc_lfsr_q[TPLC_TAP_15]; // RULE2

	// Next bit selection, coding and cell timing
	always_comb begin
		tx_state_d = tx_state_q;
		half_cnt_d = half_cnt_q + 1'b1;
		cell_d     = cell_q;
		shift_d    = shift_q;
		left_d     = left_q;
		sig_cnt_d  = sig_cnt_q;
		enc_lfsr_d = enc_lfsr_q;
		coded_d    = coded_q;
		track_d    = track_q;
		raw_bit    = 1'b0;
		buf_pop    = 1'b0;
		if (half_tick) begin
			half_cnt_d = '0;
			cell_d     = ~cell_q;
			if (cell_q) begin
				// A word already started is finished first
				if (tx_state_q == TPLC_TX_DATA && left_q != '0) begin
					raw_bit = shift_q[TPLC_WORD_W-1];
					shift_d = {shift_q[TPLC_WORD_W-2:0], 1'b0};
					left_d  = left_q - 1'b1;
				end else if (cfg_in.signature_en) begin
					// Signature bits run on the same bit tick as data
					tx_state_d = TPLC_TX_SIG; // RULE19
					raw_bit    = sig_cnt_q[1];
					sig_cnt_d  = sig_cnt_q + 1'b1;
				end else if (buf_valid) begin
					tx_state_d = TPLC_TX_DATA;
					buf_pop    = 1'b1;
					raw_bit    = buf_data[TPLC_WORD_W-1];
					shift_d    = {buf_data[TPLC_WORD_W-2:0], 1'b0};
					left_d     = TPLC_WORD_LAST;
				end else begin
					// Idle line carries coded zeros
					tx_state_d = TPLC_TX_IDLE;
				end
				// Own output bit is fed back into stage one
				enc_lfsr_d = {enc_lfsr_q[TPLC_LFSR_STAGES-2:0], scr_bit}; // RULE1 RULE4
				case (cfg_in.mode) // RULE5
					TPLC_SCRAMBLED_LEVEL_CODE: begin
						coded_d = scr_bit;
					end
					default: begin
						coded_d = raw_bit;
					end
				endcase
				// First half cell shows the coded bit
				track_d = coded_d; // RULE6
			end else begin
				// Second half inverts for split-phase, holds for scrambled
				case (cfg_in.mode)
					TPLC_SCRAMBLED_LEVEL_CODE: begin
						track_d = coded_q;
					end
					default: begin
						track_d = ~coded_q; // RULE6
					end
				endcase
			end
		end
	end

	// Record side registers
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tx_state_q <= TPLC_TX_IDLE;
			half_cnt_q <= '0;
			cell_q     <= 1'b1;
			shift_q    <= '0;
			left_q     <= '0;
			sig_cnt_q  <= '0;
			enc_lfsr_q <= TPLC_LFSR_RESET;
			coded_q    <= 1'b0;
			track_q    <= 1'b0;
		end else if (ce_in) begin
			tx_state_q <= tx_state_d;
			half_cnt_q <= half_cnt_d;
			cell_q     <= cell_d;
			shift_q    <= shift_d;
			left_q     <= left_d;
			sig_cnt_q  <= sig_cnt_d;
			enc_lfsr_q <= enc_lfsr_d;
			coded_q    <= coded_d;
			track_q    <= track_d;
		end
	end

	// One flip-flop drives the single track with two levels only
	assign track_out = track_q; // RULE13 RULE14

	// Playback side: slicer with baseline restoration
	// The baseline follows the mean only for slow scrambled playback
	// Elsewhere the threshold sits at zero amplitude
	logic signed [15:0] base_q, base_d;       // Baseline estimate, 8.8 format
	logic signed [16:0] base_err;             // Sample minus baseline
	logic signed [7:0]  sample;               // Incoming amplitude
	logic               lvl_q, lvl_d;         // Regenerated level
	logic               lvl_prev_q;           // Level one cycle earlier
	logic               restore_en;           // Baseline tracking active

	assign sample     = $signed(play_sample_in);
	// Restoration runs for scrambled code at slow playback
	assign restore_en = (cfg_in.mode == TPLC_SCRAMBLED_LEVEL_CODE) && cfg_in.low_rate; // RULE15
	assign base_err   = $signed({sample[7], sample, 8'h00}) - $signed({base_q[15], base_q});

	// Baseline filter and two-level slicer
	always_comb begin
		base_d = TPLC_BASE_RESET;
		if (restore_en) begin
			base_d = base_q + 16'(base_err >>> TPLC_DC_SHIFT); // RULE15
		end
		// Noisy samples become a clean two-level signal
		lvl_d = (sample > $signed(base_q[15:8])); // RULE13 RULE20
	end

	// Slicer registers
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			base_q     <= TPLC_BASE_RESET;
			lvl_q      <= 1'b0;
			lvl_prev_q <= 1'b0;
		end else if (ce_in) begin
			base_q     <= base_d;
			lvl_q      <= lvl_d;
			lvl_prev_q <= lvl_q;
		end
	end

	assign play_level_out = lvl_q;

	// Playback side: bit synchronizer and decoder
	// A phase accumulator wraps once per bit and is pulled by edges
	// Split-phase steers on mid-bit edges, scrambled on boundaries
	logic [15:0]        phase_q, phase_d;     // Bit phase, wraps per bit
	logic signed [15:0] phase_err;            // Phase error at a transition
	logic [15:0]        phase_adv;            // Phase after the nominal step
	logic               trans;                // Level changed
	logic [1:0]         quad_now;             // Current phase quadrant
	logic [1:0]         quad_next;            // Next phase quadrant
	logic               half1_q, half1_d;     // First half cell sample
	logic [14:0]        dec_lfsr_q, dec_lfsr_d; // Descrambler stages
	tplc_rx_bit_t       rx_q, rx_d;           // Recovered bit and strobe

	assign trans     = lvl_q ^ lvl_prev_q;
	assign phase_adv = phase_q + TPLC_NCO_STEP;
	assign quad_now  = phase_q[15:14];

	// Phase error, correction and sampling
	always_comb begin
		phase_err  = '0;
		half1_d    = half1_q;
		dec_lfsr_d = dec_lfsr_q;
		rx_d       = '0;
		if (trans) begin
			case (cfg_in.mode)
				TPLC_SCRAMBLED_LEVEL_CODE: begin
					// Edges belong at the bit boundary
					phase_err = $signed(phase_q);
				end
				default: begin
					// Only mid-bit edges steer the loop
					if (quad_now == 2'h1 || quad_now == 2'h2) begin
						phase_err = $signed(phase_q - TPLC_PHASE_MID);
					end
				end
			endcase
		end
		// Small fixed gain keeps the loop bandwidth narrow
		phase_d = phase_adv - 16'(phase_err >>> TPLC_LOOP_SHIFT); // RULE16
		quad_next = phase_d[15:14];
		case (cfg_in.mode)
			TPLC_SCRAMBLED_LEVEL_CODE: begin
				// Sample at mid-bit and descramble
				if (quad_now != 2'h2 && quad_next == 2'h2) begin
					rx_d.valid = 1'b1;
					rx_d.data  = lvl_q ^ dec_lfsr_q[TPLC_TAP_14] ^ dec_lfsr_q[TPLC_TAP_15]; // RULE4
					// Received stream itself enters the register
					dec_lfsr_d = {dec_lfsr_q[TPLC_LFSR_STAGES-2:0], lvl_q}; // RULE1 RULE3
				end
			end
			default: begin
				// First half cell level gives the bit value
				if (quad_now != 2'h1 && quad_next == 2'h1) begin
					half1_d = lvl_q;
				end
				if (quad_now != 2'h3 && quad_next == 2'h3) begin
					rx_d.valid = 1'b1;
					rx_d.data  = half1_q; // RULE6
				end
			end
		endcase
	end

	// Synchronizer and decoder registers
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			phase_q    <= TPLC_PHASE_RESET;
			half1_q    <= 1'b0;
			dec_lfsr_q <= TPLC_LFSR_RESET;
			rx_q       <= '0;
		end else if (ce_in) begin
			phase_q    <= phase_d;
			half1_q    <= half1_d;
			dec_lfsr_q <= dec_lfsr_d;
			rx_q       <= rx_d;
		end
	end

	assign play_bit_out = rx_q;

endmodule

`default_nettype wire

// ==== testbench/tplc_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none

// Port checker for the tape line coder
module tplc_monitor
	import tplc_pkg::*;
(
	// Clock, reset, enable, configuration
	input wire logic         clk_in,
	input wire logic         reset_in,
	input wire logic         ce_in,
	input wire tplc_cfg_t    cfg_in,
	// Source side
	input wire logic         src_valid_in,
	input wire logic         src_ready_out,
	input wire logic [7:0]   src_data_in,
	// Track and playback
	input wire logic         track_out,
	input wire logic [7:0]   play_sample_in,
	input wire logic         play_level_out,
	input wire tplc_rx_bit_t play_bit_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	// A level change on the track
	sequence s_edge;
		$changed(track_out);
	endsequence
	// A half cell that stands its full four cycles
	sequence s_half_hold;
		$stable(track_out)[*3];
	endsequence

	a_reset_quiet: assert property (disable iff (1'b0) reset_in |=>
		!track_out && src_ready_out && !play_level_out && play_bit_out == '0)
		else $error("outputs not quiet after reset");
	a_half_hold: assert property (s_edge |=> s_half_hold)
		else $error("track level shorter than a half cell");
	a_mid_change: assert property (disable iff (reset_in || !ce_in)
		(cfg_in.mode == TPLC_SPLIT_PHASE_LEVEL_CODE && $changed(track_out))
		|-> ##[1:8] $changed(track_out)) else $error("split-phase lost its mid-bit edge");
	a_scr_bit_hold: assert property (
		(cfg_in.mode == TPLC_SCRAMBLED_LEVEL_CODE && $changed(track_out))
		|=> $stable(track_out)[*7]) else $error("scrambled bit not held a full period");
	a_level_regen: assert property ((ce_in && !cfg_in.low_rate) |=>
		play_level_out == ($signed($past(play_sample_in)) > 0))
		else $error("playback level not regenerated from sample");
	a_bit_pulse: assert property (disable iff (reset_in || !ce_in)
		play_bit_out.valid |=> !play_bit_out.valid [*5])
		else $error("recovered bits too close together");
	a_freeze_hold: assert property ((!ce_in && !reset_in) |=>
		$stable(track_out) && $stable(play_bit_out) && $stable(src_ready_out))
		else $error("state moved while enable low");
	a_ready_falls: assert property ($fell(src_ready_out) |->
		$past(src_valid_in && ce_in)) else $error("ready fell without a write");
endmodule

bind tplc_line_coder tplc_monitor u_mon (
	.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .cfg_in(cfg_in),
	.src_valid_in(src_valid_in), .src_ready_out(src_ready_out), .src_data_in(src_data_in),
	.track_out(track_out), .play_sample_in(play_sample_in),
	.play_level_out(play_level_out), .play_bit_out(play_bit_out)
);

`default_nettype wire

// ==== testbench/tplc_tape_track.sv ====
`timescale 1ns/10ps
`default_nettype none

// Tape track: replays the record level as a signed amplitude a clock later
module tplc_tape_track (
	// Clock
	input  wire logic       clk_in,
	// Record level and channel impairments
	input  wire logic       track_in,
	input  wire logic       noise_in,
	input  wire logic [7:0] offset_in,
	// Playback amplitude
	output logic [7:0]      sample_out
);
	logic flip_q = 1'b0; // Ripple sign, alternates every clock

	// One track carries all; noise and dc shift mimic a worn head
	// Direct serial record replayed at record speed keeps rate and density in range
	always_ff @(posedge clk_in) begin
		flip_q     <= ~flip_q;
		sample_out <= (track_in ? 8'h30 : 8'hd0) + offset_in
			+ (noise_in ? (flip_q ? 8'h0c : 8'hf4) : 8'h00);
	end
endmodule

`default_nettype wire

// ==== testbench/tplc_line_coder_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

// Bench: words recorded, track looped back to playback
module tplc_line_coder_bench import tplc_pkg::*;;
	localparam logic [7:0] WORDS [6] = '{8'ha5, 8'h3c, 8'hf0, 8'h96, 8'h5a, 8'hc3};
	logic         clk_in, reset_in, ce_in;   // Clock, reset, enable
	tplc_cfg_t    cfg;                       // Configuration
	logic         src_valid, src_ready;      // Source handshake
	logic [7:0]   src_data, sample, offset;  // Word, amplitude, dc shift
	logic         track, level, noise, rec;  // Track, level, ripple, record on
	tplc_rx_bit_t pbit;                      // Recovered bit
	logic         trk_q[$], bit_q[$];        // Captured track and bits
	logic         exp_q[$], bex_q[$];        // Expected track and bits
	int           n_fail, compares, low_n;   // Counters

	tplc_line_coder DUT (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
		.cfg_in(cfg), .src_valid_in(src_valid), .src_ready_out(src_ready),
		.src_data_in(src_data), .track_out(track), .play_sample_in(sample),
		.play_level_out(level), .play_bit_out(pbit));
	tplc_tape_track u_tape (.clk_in(clk_in), .track_in(track), .noise_in(noise),
		.offset_in(offset), .sample_out(sample));

	// 25 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	// Capture the track, recovered bits and refusal cycles where outputs are settled
	always @(negedge clk_in) begin
		if (rec) begin
			trk_q.push_back(track);
			if (pbit.valid) bit_q.push_back(pbit.data);
			if (!src_ready) low_n++;
		end
	end

	task automatic wrap_up();
		$display("counts: compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// True when the needle sequence appears anywhere in the haystack
	function automatic logic found(logic h[$], logic n[$]);
		int i, k;
		found = 1'b0;
		for (i = 0; i + n.size() <= h.size(); i++) begin
			for (k = 0; k < n.size() && h[i+k] === n[k]; k++) ;
			if (k == n.size()) found = 1'b1;
		end
	endfunction

	task automatic do_reset(input tplc_mode_t m, input logic lr, input logic sg);
		@(posedge clk_in);
		reset_in <= 1'b1;
		rec      <= 1'b0;
		cfg      <= '{mode: m, low_rate: lr, signature_en: sg};
		repeat (8) @(posedge clk_in);
		trk_q.delete();
		bit_q.delete();
		low_n    = 0;
		reset_in <= 1'b0;
		rec      <= 1'b1;
	endtask

	// Offer a word and hold it until an edge sees ready high
	task automatic send(input logic [7:0] w);
		int n;
		src_valid <= 1'b1;
		src_data  <= w;
		#1;
		for (n = 0; !src_ready && n < 200; n++) begin
			@(posedge clk_in);
			#1;
		end
		if (n == 200) begin
			check(0, 1);
			wrap_up();
		end
		@(posedge clk_in);
	endtask

	// Record all words back to back and build the expected streams
	task automatic run_words(input tplc_mode_t m, input logic lr);
		logic [14:0] s;
		logic        d, c;
		do_reset(m, lr, 1'b0);
		for (int w = 0; w < 6; w++) send(WORDS[w]);
		src_valid <= 1'b0;
		repeat (560) @(posedge clk_in);
		exp_q.delete();
		bex_q.delete();
		s = TPLC_LFSR_RESET;
		for (int w = 0; w < 6; w++) begin
			for (int b = 7; b >= 0; b--) begin
				d = WORDS[w][b];
				c = d ^ s[TPLC_TAP_14] ^ s[TPLC_TAP_15];
				s = {s[13:0], c};
				if (w > 0) bex_q.push_back(d);
				for (int h = 0; h < 8; h++)
					exp_q.push_back(m == TPLC_SPLIT_PHASE_LEVEL_CODE ? d ^ (h > 3) : c);
			end
		end
	endtask

	task automatic t_reset();
		do_reset(TPLC_SPLIT_PHASE_LEVEL_CODE, 1'b0, 1'b0);
		#1;
		check({src_ready, track, level, pbit}, 5'h10);
	endtask

	// Noisy split-phase record and playback, FIFO filled until refused
	task automatic t_split();
		noise  <= 1'b1;
		offset <= 8'h00;
		run_words(TPLC_SPLIT_PHASE_LEVEL_CODE, 1'b0);
		check(found(trk_q, exp_q), 1);
		check(found(bit_q, bex_q), 1);
		check(low_n > 0, 1);
	endtask

	// Scrambled record and playback with dc shift and restoration on
	task automatic t_scrambled();
		noise  <= 1'b0;
		offset <= 8'h10;
		run_words(TPLC_SCRAMBLED_LEVEL_CODE, 1'b1);
		check(found(trk_q, exp_q), 1);
		check(found(bit_q, bex_q), 1);
	endtask

	// Signature 0011 at the 8-cycle payload bit period
	task automatic t_signature();
		offset <= 8'h00;
		do_reset(TPLC_SPLIT_PHASE_LEVEL_CODE, 1'b0, 1'b1);
		repeat (200) @(posedge clk_in);
		exp_q.delete();
		for (int b = 0; b < 8; b++)
			for (int h = 0; h < 8; h++) exp_q.push_back(b[1] ^ (h > 3));
		check(found(trk_q, exp_q), 1);
	endtask

	// Enable low in mid-word freezes the track
	task automatic t_freeze();
		logic lv;
		do_reset(TPLC_SCRAMBLED_LEVEL_CODE, 1'b0, 1'b0);
		send(8'h6d);
		src_valid <= 1'b0;
		repeat (30) @(posedge clk_in);
		ce_in <= 1'b0;
		@(negedge clk_in);
		lv = track;
		repeat (20) @(negedge clk_in);
		check(track, lv);
		@(posedge clk_in);
		ce_in <= 1'b1;
	endtask

	initial begin
		reset_in  = 1'b1;
		ce_in     = 1'b1;
		cfg       = '0;
		src_valid = 1'b0;
		src_data  = 8'h00;
		noise     = 1'b0;
		offset    = 8'h00;
		rec       = 1'b0;
		n_fail    = 0;
		compares  = 0;
		low_n     = 0;
		t_reset();
		t_split();
		t_scrambled();
		t_signature();
		t_freeze();
		wrap_up();
	end
endmodule

`default_nettype wire
